//--- rtl/byte_fifo.sv
// flip-flop byte fifo with push and pop ports
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic flush,
    // write side
    input wire logic push,
    input wire logic [7:0] wdata,
    output logic full,
    // read side
    input wire logic pop,
    output logic [7:0] rdata,
    output logic empty,
    output logic [AW:0] count
);
    logic [7:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    assign full = (cnt_q == (AW+1)'(DEPTH));
    assign empty = (cnt_q == '0);
    assign count = cnt_q;
    assign rdata = mem_q[rp_q];

    always_ff @(posedge hclk) begin
        if (do_push) begin
            mem_q[wp_q] <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (do_pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : byte_fifo
`default_nettype wire

//--- rtl/fifo_port_pkg.sv
// constants, widths and timing counts for the parallel fifo port
package fifo_port_pkg;
    localparam int CLK_MHZ = 50;
    localparam int CLK_NS = 20;
    localparam int RX_DEPTH = 128;
    localparam int TX_DEPTH = 256;
    localparam int RX_AW = 7;
    localparam int TX_AW = 8;
    // flag inactive time after a load strobe, in ns
    localparam int FLAG_HOLD_NS = 80;
    localparam int FLAG_HOLD_CYC = (FLAG_HOLD_NS + CLK_NS - 1) / CLK_NS;
    // one millisecond in cycles
    localparam int MS_CYC = CLK_MHZ * 1000;
    localparam int WAKE_MS = 20;
    localparam logic [7:0] TMO_DEFAULT_MS = 8'h10;
    localparam logic [7:0] TMO_MIN_MS = 8'h02;
    localparam logic [15:0] BB_DIV_DEFAULT = 16'h0032;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RXDATA = 8'h08;
    localparam logic [7:0] ADDR_TXDATA = 8'h0C;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h10;
    localparam logic [7:0] ADDR_BBDIV = 8'h14;
    localparam logic [7:0] ADDR_BBDIR = 8'h18;
    localparam logic [7:0] ADDR_BBIN = 8'h1C;
    // control field positions
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_SUSPEND = 2;
    localparam int CTRL_WAKE_EN = 3;
    localparam int CTRL_CONFIGURED = 4;
    localparam logic [4:0] CTRL_RESET = 5'h08;
    typedef enum logic [1:0] {
        MODE_FIFO = 2'h0,
        MODE_ASYNC_BB = 2'h1,
        MODE_SYNC_BB = 2'h2
    } port_mode_t;
endpackage : fifo_port_pkg

//--- rtl/usb_parallel_fifo_port.sv
// parallel fifo port of a usb device, with ahb-lite register access
// Behaviour
// RL1 - controller holds load strobe 50 ns
// RL2 - controller leaves 50 ns between load strobes
// RL3 - load-allowed inactive after strobe, 80 ns
// RL4 - byte captured at load strobe falling edge
// RL5 - controller loads only while load-allowed low
// RL6 - unload-available low whenever receive data held; the code holds it high outside fifo mode
// RL7 - fetch low drives byte, falling edge advances
// RL8 - async bit-bang plays bytes at timer rate
// RL9 - sync bit-bang samples pins on each write
// RL10 - receive timeout flushes, default 16 ms
// RL11 - suspended with wake enabled: pin becomes input
// RL12 - external logic holds pin low 20 ms
// RL13 - long low pin during suspend requests resume
// RL14 - host data into 128-byte receive buffer
// RL15 - loaded bytes into 256-byte transmit buffer
// RL16 - fifo logic runs from one reference clock
// RL17 - bit-bang timer derived from that clock
// RL18 - controller moves bytes between buffers and lines
// RL19 - reset on power-up and external reset
// RL20 - full transmit buffer blocks and ignores loads
// RL21 - data lines released when fetch returns high
`timescale 1ns/10ps
`default_nettype none
module usb_parallel_fifo_port
    import fifo_port_pkg::*;
#(
    parameter int TMO_UNIT_CYC = MS_CYC,
    parameter int WAKE_CYC = WAKE_MS * MS_CYC
) (
    // ahb-lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // parallel data lines
    input wire logic [7:0] fifo_byte_lines_i,
    output logic [7:0] fifo_byte_lines_o,
    output logic [7:0] fifo_byte_lines_oe,
    // strobes and flags
    input wire logic fetch_n,
    input wire logic load,
    output logic load_allowed_n,
    input wire logic unload_available_n_i,
    output logic unload_available_n_o,
    output logic unload_available_n_oe,
    output logic configured_power_n,
    // usb side events
    output logic resume_req
);
    // register state
    logic [4:0] ctrl_q;
    logic [7:0] tmo_q;
    logic [15:0] bbdiv_q;
    logic [7:0] bbdir_q;
    logic [7:0] bbin_q;
    logic [7:0] bbout_q;
    // ahb address phase capture
    logic wr_pend_q, rd_pend_q;
    logic [7:0] addr_q;
    // pin edge detection and flag timing
    logic fetch_n_q, load_q;
    logic [2:0] hold_q;
    logic [31:0] tmo_cnt_q;
    logic [15:0] bb_cnt_q;
    logic [31:0] wake_cnt_q;
    logic resume_q;
    logic [7:0] rx_drive_q;

    port_mode_t mode;
    assign mode = port_mode_t'(ctrl_q[CTRL_MODE_LO +: 2]);
    wire suspended = ctrl_q[CTRL_SUSPEND];
    wire wake_en = ctrl_q[CTRL_WAKE_EN];
    wire fifo_mode = (mode == MODE_FIFO);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : hit

    // ahb decode
    wire addr_phase = hsel && hready && htrans[1];
    wire wr_ctrl = wr_pend_q && hit(addr_q, ADDR_CTRL);
    wire wr_tx = wr_pend_q && hit(addr_q, ADDR_TXDATA);
    wire wr_tmo = wr_pend_q && hit(addr_q, ADDR_TIMEOUT);
    wire wr_div = wr_pend_q && hit(addr_q, ADDR_BBDIV);
    wire wr_dir = wr_pend_q && hit(addr_q, ADDR_BBDIR);
    wire wr_rx = wr_pend_q && hit(addr_q, ADDR_RXDATA);

    // buffers
    logic rx_push, rx_pop, rx_full, rx_empty, rx_flush;
    logic [7:0] rx_rdata;
    logic [RX_AW:0] rx_count;
    logic tx_push, tx_pop, tx_full, tx_empty;
    logic [7:0] tx_rdata;
    logic [TX_AW:0] tx_count;

    // pin edges, inputs are synchronous to hclk
    wire fetch_fall = fetch_n_q && !fetch_n;
    wire load_fall = load_q && !load;
    wire bb_tick = (bb_cnt_q == '0);
    wire tmo_hit = (tmo_cnt_q >= 32'(tmo_q) * 32'(TMO_UNIT_CYC));

    // host writes fill the receive buffer; async bit-bang drains it by timer.
    // sync bit-bang sends writes straight to the pins, as nothing would drain them
    assign rx_push = wr_rx && !rx_full && (mode != MODE_SYNC_BB); // [RL14]
    assign rx_pop = fifo_mode ? fetch_fall : (mode == MODE_ASYNC_BB && bb_tick); // [RL7] [RL8]
    assign rx_flush = fifo_mode && tmo_hit && !rx_empty; // [RL10]
    // loads taken only in fifo mode, only while not full
    assign tx_push = fifo_mode && load_fall && !tx_full; // [RL4] [RL20]
    assign tx_pop = rd_pend_q && hit(addr_q, ADDR_TXDATA); // [RL15]

    byte_fifo #(.DEPTH(RX_DEPTH), .AW(RX_AW)) u_rx ( // [RL16]
        .hclk(hclk), .hresetn(hresetn), .flush(rx_flush),
        .push(rx_push), .wdata(hwdata[7:0]), .full(rx_full),
        .pop(rx_pop), .rdata(rx_rdata), .empty(rx_empty), .count(rx_count)
    );
    byte_fifo #(.DEPTH(TX_DEPTH), .AW(TX_AW)) u_tx (
        .hclk(hclk), .hresetn(hresetn), .flush(1'b0),
        .push(tx_push), .wdata(fifo_byte_lines_i), .full(tx_full),
        .pop(tx_pop), .rdata(tx_rdata), .empty(tx_empty), .count(tx_count)
    );

    // flags and pins
    wire wake_input = suspended && wake_en; // [RL11]
    // load_q bridges the cycle between the strobe fall and the hold timer start
    assign load_allowed_n = !fifo_mode || tx_full || (hold_q != '0) || load || load_q; // [RL3] [RL20]
    assign unload_available_n_o = rx_empty || !fifo_mode; // [RL6]
    assign unload_available_n_oe = !wake_input; // [RL11]
    assign configured_power_n = !ctrl_q[CTRL_CONFIGURED] || suspended;
    assign fifo_byte_lines_o = fifo_mode ? rx_drive_q : bbout_q; // [RL18]
    assign fifo_byte_lines_oe = fifo_mode ? {8{!fetch_n}} : bbdir_q; // [RL7] [RL21]
    assign resume_req = resume_q;

    // ahb answer: zero wait states, always okay
    wire [31:0] status_w = {13'h0000, tx_count, rx_count, tx_full, tx_empty};
    wire [31:0] rd_mux =
        hit(addr_q, ADDR_CTRL) ? {27'h0000000, ctrl_q} :
        hit(addr_q, ADDR_STATUS) ? status_w :
        hit(addr_q, ADDR_RXDATA) ? {24'h000000, rx_rdata} :
        hit(addr_q, ADDR_TXDATA) ? {23'h000000, tx_empty, tx_rdata} :
        hit(addr_q, ADDR_TIMEOUT) ? {24'h000000, tmo_q} :
        hit(addr_q, ADDR_BBDIV) ? {16'h0000, bbdiv_q} :
        hit(addr_q, ADDR_BBDIR) ? {24'h000000, bbdir_q} :
        hit(addr_q, ADDR_BBIN) ? {24'h000000, bbin_q} : 32'h00000000;
    assign hrdata = rd_pend_q ? rd_mux : 32'h00000000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin // [RL19]
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            rd_pend_q <= addr_phase && !hwrite;
            if (addr_phase) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET; // [RL11]
            tmo_q <= TMO_DEFAULT_MS; // [RL10]
            bbdiv_q <= BB_DIV_DEFAULT;
            bbdir_q <= 8'h00;
        end else begin
            if (wr_ctrl) ctrl_q <= hwdata[4:0];
            if (wr_tmo && hwdata[7:0] >= TMO_MIN_MS) tmo_q <= hwdata[7:0]; // [RL10]
            if (wr_div) bbdiv_q <= hwdata[15:0];
            if (wr_dir) bbdir_q <= hwdata[7:0];
        end
    end

    // bit-bang output and sampling
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bbout_q <= 8'h00;
            bbin_q <= 8'h00;
            bb_cnt_q <= 16'h0000;
        end else begin
            bb_cnt_q <= bb_tick ? bbdiv_q : bb_cnt_q - 16'h0001; // [RL17]
            if (mode == MODE_ASYNC_BB) begin
                if (bb_tick && !rx_empty) bbout_q <= rx_rdata; // [RL8]
                bbin_q <= fifo_byte_lines_i;
            end else if (mode == MODE_SYNC_BB && wr_rx) begin
                bbout_q <= hwdata[7:0];
                bbin_q <= fifo_byte_lines_i; // [RL9]
            end
        end
    end

    // strobe edges, flag hold timer, fetch data latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fetch_n_q <= 1'b1;
            load_q <= 1'b0;
            hold_q <= 3'h0;
            rx_drive_q <= 8'h00;
        end else begin
            fetch_n_q <= fetch_n;
            load_q <= load;
            if (load_fall) hold_q <= 3'(FLAG_HOLD_CYC); // [RL3]
            else if (hold_q != '0) hold_q <= hold_q - 3'h1;
            if (fetch_fall) rx_drive_q <= rx_rdata; // [RL7]
        end
    end

    // receive timeout and wake-up detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmo_cnt_q <= 32'h00000000;
            wake_cnt_q <= 32'h00000000;
            resume_q <= 1'b0;
        end else begin
            if (rx_empty || rx_push || rx_pop || rx_flush) tmo_cnt_q <= 32'h00000000;
            else tmo_cnt_q <= tmo_cnt_q + 32'h00000001;
            resume_q <= 1'b0;
            if (!wake_input || unload_available_n_i) begin
                wake_cnt_q <= 32'h00000000;
            end else if (wake_cnt_q == 32'(WAKE_CYC) - 32'h00000001) begin
                resume_q <= 1'b1; // [RL13]
                wake_cnt_q <= wake_cnt_q + 32'h00000001;
            end else if (wake_cnt_q < 32'(WAKE_CYC)) begin
                wake_cnt_q <= wake_cnt_q + 32'h00000001;
            end
        end
    end

    // checks
    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        load_fall |-> load_allowed_n [*4];
    endproperty
    a_hold: assert property (p_hold) else $error("load flag not held inactive"); // [RL3]
    property p_full;
        @(posedge hclk) disable iff (!hresetn) tx_full |-> load_allowed_n && !tx_push;
    endproperty
    a_full: assert property (p_full) else $error("load allowed while full"); // [RL20]
    property p_rxflag;
        @(posedge hclk) disable iff (!hresetn)
        fifo_mode |-> (unload_available_n_o == rx_empty);
    endproperty
    a_rxflag: assert property (p_rxflag) else $error("receive flag wrong"); // [RL6]
    property p_release;
        @(posedge hclk) disable iff (!hresetn)
        (fifo_mode && fetch_n) |-> fifo_byte_lines_oe == 8'h00;
    endproperty
    a_release: assert property (p_release) else $error("lines driven after fetch"); // [RL21]
    property p_capture;
        @(posedge hclk) disable iff (!hresetn)
        (tx_push && tx_empty) |=> tx_rdata == $past(fifo_byte_lines_i);
    endproperty
    a_capture: assert property (p_capture) else $error("loaded byte not captured"); // [RL4]
    property p_wake;
        @(posedge hclk) disable iff (!hresetn) wake_input |-> !unload_available_n_oe;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pin still driven"); // [RL11]
    property p_resume;
        @(posedge hclk) disable iff (!hresetn) resume_q |-> wake_input;
    endproperty
    a_resume: assert property (p_resume) else $error("resume outside suspend"); // [RL13]
    property p_sync;
        @(posedge hclk) disable iff (!hresetn)
        (mode == MODE_SYNC_BB && !wr_rx) |=> $stable(bbin_q);
    endproperty
    a_sync: assert property (p_sync) else $error("sync sample without write"); // [RL9]
    property p_async;
        @(posedge hclk) disable iff (!hresetn)
        (mode == MODE_ASYNC_BB && bb_tick && !rx_empty) |=> bbout_q == $past(rx_rdata);
    endproperty
    a_async: assert property (p_async) else $error("async byte not presented"); // [RL8]
    property p_flush;
        @(posedge hclk) disable iff (!hresetn) rx_flush |=> rx_empty;
    endproperty
    a_flush: assert property (p_flush) else $error("timeout did not flush"); // [RL10]
    property p_tmo_min;
        @(posedge hclk) disable iff (!hresetn) tmo_q >= TMO_MIN_MS;
    endproperty
    a_tmo_min: assert property (p_tmo_min) else $error("timeout below minimum"); // [RL10]
    property p_resume_once;
        @(posedge hclk) disable iff (!hresetn) resume_q |=> !resume_q;
    endproperty
    a_resume_once: assert property (p_resume_once) else $error("resume pulse too long"); // [RL13]
    property p_rx_guard;
        @(posedge hclk) disable iff (!hresetn) rx_full |-> !rx_push;
    endproperty
    a_rx_guard: assert property (p_rx_guard) else $error("push into full buffer"); // [RL14]
    c_sync: cover property (@(posedge hclk) mode == MODE_SYNC_BB && wr_rx);
    c_load: cover property (@(posedge hclk) tx_push);
    c_fetch: cover property (@(posedge hclk) rx_pop && fifo_mode);
    c_flush: cover property (@(posedge hclk) rx_flush);
    c_resume: cover property (@(posedge hclk) resume_q);
endmodule : usb_parallel_fifo_port
`default_nettype wire

//--- verification/fifo_port_partner.sv
// far-side controller model that loads and fetches bytes on the parallel port
`timescale 1ns/10ps
`default_nettype none
module fifo_port_partner (
    // clock
    input wire logic hclk,
    // resolved pins seen from the far side
    input wire logic [7:0] lines,
    input wire logic load_allowed_n,
    input wire logic unload_pin,
    // far-side drives
    output logic [7:0] data,
    output logic load,
    output logic fetch_n,
    output logic wake_n
);
    logic load_d;
    initial begin
        data = 8'h00;
        load = 1'b0;
        fetch_n = 1'b1;
        wake_n = 1'b1;
        load_d = 1'b0;
    end
    // data held one edge past the strobe fall, then inverted so a stale byte never passes
    always @(posedge hclk) begin
        load_d <= load;
        if (load_d && !load) begin
            data <= ~data;
        end
    end
    task automatic set_data(input logic [7:0] b);
        data <= b;
    endtask : set_data
    // flags are looked at just after the edge, once they have settled
    task automatic put_byte(input logic [7:0] b);
        #1;
        while (load_allowed_n !== 1'b0) begin
            @(posedge hclk);
            #1;
        end
        @(posedge hclk);
        data <= b;
        load <= 1'b1;
        repeat (3) @(posedge hclk);
        load <= 1'b0;
    endtask : put_byte
    task automatic get_byte(output logic [7:0] b);
        #1;
        while (unload_pin !== 1'b0) begin
            @(posedge hclk);
            #1;
        end
        @(posedge hclk);
        fetch_n <= 1'b0;
        repeat (3) @(posedge hclk);
        b = lines;
        fetch_n <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask : get_byte
    task automatic wake(input int cyc);
        @(posedge hclk);
        wake_n <= 1'b0;
        repeat (cyc) @(posedge hclk);
        wake_n <= 1'b1;
    endtask : wake
endmodule : fifo_port_partner
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the parallel fifo port
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import fifo_port_pkg::*;
    // short counts keep the timeout and wake runs brief
    localparam int TMO_UNIT = 10;
    localparam int WAKE = 20;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic load, fetch_n, load_allowed_n, una_o, una_oe, wake_n, cfg_n, resume_req;
    logic [7:0] lines_o, lines_oe, p_data, lines, b;
    logic una_pin;
    int fails, total_checks, cyc, resumes;
    assign lines = (lines_oe & lines_o) | (~lines_oe & p_data);
    // pin is pulled up, so a released pin with no wake drive reads high
    assign una_pin = una_oe ? una_o : wake_n;
    usb_parallel_fifo_port #(.TMO_UNIT_CYC(TMO_UNIT), .WAKE_CYC(WAKE)) usb_parallel_fifo_port_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fifo_byte_lines_i(lines), .fifo_byte_lines_o(lines_o), .fifo_byte_lines_oe(lines_oe),
        .fetch_n(fetch_n), .load(load), .load_allowed_n(load_allowed_n),
        .unload_available_n_i(una_pin), .unload_available_n_o(una_o),
        .unload_available_n_oe(una_oe), .configured_power_n(cfg_n), .resume_req(resume_req));
    fifo_port_partner fifo_port_partner_inst (
        .hclk(hclk), .lines(lines), .load_allowed_n(load_allowed_n), .unload_pin(una_pin),
        .data(p_data), .load(load), .fetch_n(fetch_n), .wake_n(wake_n));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (resume_req === 1'b1) begin
            resumes <= resumes + 1;
        end
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(a, 1'b1, d, x);
    endtask : wr
    task automatic t_reset();
        ahb(ADDR_CTRL, 1'b0, 32'h0, v);
        check(v, {27'h0, CTRL_RESET});
        ahb(ADDR_TIMEOUT, 1'b0, 32'h0, v);
        check(v, {24'h0, TMO_DEFAULT_MS});
        ahb(ADDR_BBDIV, 1'b0, 32'h0, v);
        check(v, {16'h0, BB_DIV_DEFAULT});
        ahb(ADDR_STATUS, 1'b0, 32'h0, v);
        check(v, 32'h1);
        ahb(8'h40, 1'b0, 32'h0, v);
        check(v, 32'h0);
        check(32'(hresp), 32'h0);
        check(32'(una_o), 32'h1);
    endtask : t_reset
    task automatic t_load();
        fifo_port_partner_inst.put_byte(8'h5A);
        for (int i = 0; i < 4; i++) begin
            #1 check(32'(load_allowed_n), 32'h1);
            @(posedge hclk);
        end
        fifo_port_partner_inst.put_byte(8'hC3);
        repeat (3) @(posedge hclk);
        ahb(ADDR_STATUS, 1'b0, 32'h0, v);
        check(v, 32'h800);
        ahb(ADDR_TXDATA, 1'b0, 32'h0, v);
        check(v, 32'h5A);
        ahb(ADDR_TXDATA, 1'b0, 32'h0, v);
        check(v, 32'hC3);
        ahb(ADDR_TXDATA, 1'b0, 32'h0, v);
        check(32'(v[8]), 32'h1);
        for (int i = 0; i < TX_DEPTH; i++) begin
            fifo_port_partner_inst.put_byte(i[7:0]);
        end
        repeat (10) @(posedge hclk);
        check(32'(load_allowed_n), 32'h1);
        ahb(ADDR_STATUS, 1'b0, 32'h0, v);
        check(v, 32'h40002);
        ahb(ADDR_TXDATA, 1'b0, 32'h0, v);
        check(v, 32'h0);
        repeat (6) @(posedge hclk);
        check(32'(load_allowed_n), 32'h0);
    endtask : t_load
    task automatic t_fetch();
        wr(ADDR_RXDATA, 32'h3C);
        wr(ADDR_RXDATA, 32'h96);
        #1 check(32'(una_o), 32'h0);
        fifo_port_partner_inst.get_byte(b);
        check(32'(b), 32'h3C);
        check(32'(lines_oe), 32'h0);
        fifo_port_partner_inst.get_byte(b);
        check(32'(b), 32'h96);
        check(32'(una_o), 32'h1);
    endtask : t_fetch
    task automatic t_timeout();
        wr(ADDR_TIMEOUT, 32'h1);
        ahb(ADDR_TIMEOUT, 1'b0, 32'h0, v);
        check(v, 32'h10);
        wr(ADDR_TIMEOUT, 32'h2);
        wr(ADDR_RXDATA, 32'h11);
        repeat (2 * TMO_UNIT - 5) @(posedge hclk);
        #1 check(32'(una_o), 32'h0);
        repeat (10) @(posedge hclk);
        #1 check(32'(una_o), 32'h1);
    endtask : t_timeout
    task automatic t_wake();
        wr(ADDR_CTRL, 32'h10);
        #1 check(32'(cfg_n), 32'h0);
        wr(ADDR_CTRL, 32'h0C);
        #1 check(32'(una_oe), 32'h0);
        check(32'(cfg_n), 32'h1);
        fifo_port_partner_inst.wake(WAKE - 5);
        repeat (5) @(posedge hclk);
        check(32'(resumes), 32'h0);
        fifo_port_partner_inst.wake(WAKE + 4);
        repeat (5) @(posedge hclk);
        check(32'(resumes), 32'h1);
        wr(ADDR_CTRL, 32'h04);
        #1 check(32'(una_oe), 32'h1);
    endtask : t_wake
    task automatic t_bitbang();
        logic [7:0] prev;
        logic [7:0] got [2];
        int pos [2];
        int n;
        n = 0;
        wr(ADDR_CTRL, 32'h02);
        wr(ADDR_BBDIR, 32'h0F);
        fifo_port_partner_inst.set_data(8'hA0);
        wr(ADDR_RXDATA, 32'h35);
        ahb(ADDR_BBIN, 1'b0, 32'h0, v);
        check(v, 32'hA0);
        fifo_port_partner_inst.set_data(8'h50);
        ahb(ADDR_BBIN, 1'b0, 32'h0, v);
        check(v, 32'hA0);
        wr(ADDR_RXDATA, 32'h3C);
        ahb(ADDR_BBIN, 1'b0, 32'h0, v);
        check(v, 32'h55);
        check(32'(lines), 32'h5C);
        // load two bytes in fifo mode so both wait for the timer
        wr(ADDR_CTRL, 32'h00);
        wr(ADDR_BBDIV, 32'h04);
        wr(ADDR_RXDATA, 32'h81);
        wr(ADDR_RXDATA, 32'h42);
        wr(ADDR_CTRL, 32'h01);
        @(negedge hclk);
        prev = lines_o;
        for (int i = 0; i < 80; i++) begin
            @(negedge hclk);
            if (lines_o !== prev && n < 2) begin
                got[n] = lines_o;
                pos[n] = i;
                n++;
            end
            prev = lines_o;
        end
        @(posedge hclk);
        check(32'(got[0]), 32'h81);
        check(32'(got[1]), 32'h42);
        // the divider counts down through zero, so a tick comes every div + 1 cycles
        check(32'(pos[1] - pos[0]), 32'h5);
        check(32'(lines_oe), 32'h0F);
    endtask : t_bitbang
    initial begin
        fails = 0;
        total_checks = 0;
        cyc = 0;
        resumes = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_load();
        t_fetch();
        t_timeout();
        t_wake();
        t_bitbang();
        final_report();
    end
endmodule : testbench
`default_nettype wire
